// ==== verilog/pbsd_pkg.sv ====
// Package: command codes, field layouts, reset values and delay tables for the status and delay block
// Notes on behaviour
// - Restore command copies every stored non-volatile setting into the working registers.
// - Restore is accepted while running; the bus is ignored during the copy.
// - Status word reads as 16 bits; status byte read returns its low byte.
// - Raw status bits follow their live condition, high only while it is present.
// - Latched flags set on their condition and hold until a clearing event.
// - Low bits 7,0 and high bits 4,2,1,0 of the status word read zero.
// - Low bit 6 is high while the converter is not delivering output power.
// - Low bit 5 latches on an output overvoltage fault.
// - Low bit 4 latches on an output overcurrent fault.
// - Low bit 3 latches when the input supply is below the turn-on threshold.
// - Low bit 2 latches on an over-temperature fault.
// - Low bit 1 latches on a communication fault: an unknown command code, or a known code with the wrong transaction kind.
// - High bits 7,6,5 latch summaries for output voltage, output current, input voltage.
// - High bit 3 reads one while the power-good pin is low.
// - Flags clear only by clear command, enable off-then-on, or supply power cycle.
// - A condition still present when cleared sets its flag and alert again at once.
// - The open-drain alert pin is driven active while any fault is flagged.
// - User storage keeps six bits, default zero; upper two bits ignored.
// - Delay bits 5:3 select the power-good delay from eight table values.
// - Delay bits 2:0 select the power-on delay from eight table values.
// - Clear command clears all flags and releases alert; it never restarts a latched-off converter.
package pbsd_pkg;
	// Command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_USER_STORAGE = 8'hD0;
	localparam logic [7:0] CMD_DELAY_SETTINGS = 8'hD1;
	// Transaction kinds seen on the command port
	typedef enum logic [1:0] {KIND_SEND, KIND_WRITE_BYTE, KIND_READ_BYTE, KIND_READ_WORD} pbsd_kind_t;
	// Non-volatile word indices
	localparam int NVM_WORDS = 2;
	localparam logic [0:0] NVM_IDX_USER = 1'h0;
	localparam logic [0:0] NVM_IDX_DELAY = 1'h1;
	// Field layout and reset values
	localparam logic [7:0] USER_MASK = 8'h3F;
	localparam logic [7:0] DELAY_MASK = 8'h3F;
	localparam int PGD_LSB = 3;
	localparam int POD_LSB = 0;
	localparam logic [7:0] USER_RESET = 8'h00;
	localparam logic [7:0] DELAY_RESET = 8'h12;
	// Status word bit positions
	localparam int ST_OFF = 6;
	localparam int ST_OV = 5;
	localparam int ST_OC = 4;
	localparam int ST_UV = 3;
	localparam int ST_OT = 2;
	localparam int ST_CML = 1;
	localparam int ST_VSUM = 15;
	localparam int ST_ISUM = 14;
	localparam int ST_INSUM = 13;
	localparam int ST_PG_LOW = 11;
	// Timing: clock period and the microsecond tick
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int DLY_W = 18;
	// Delay tables in microseconds, indexed by the 3-bit selects
	localparam logic [DLY_W-1:0] PGD_US [8] = '{18'h00100, 18'h00200, 18'h00400, 18'h00800,
		18'h01000, 18'h02000, 18'h04000, 18'h20000};
	localparam logic [DLY_W-1:0] POD_US [8] = '{18'h00164, 18'h00264, 18'h00464, 18'h00864,
		18'h01064, 18'h02064, 18'h04064, 18'h08064};
endpackage

// ==== verilog/pbsd_nvm_restore.sv ====
// Non-volatile setting store with a word-by-word restore sequencer
`timescale 1ns/10ps
`default_nettype none
module pbsd_nvm_restore #(
	parameter int WORDS = 2,
	parameter int W = 8,
	parameter logic [WORDS*W-1:0] DEFAULTS = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Programming port standing in for the store path
	input wire logic prog_valid,
	input wire logic [$clog2(WORDS)-1:0] prog_addr,
	input wire logic [W-1:0] prog_data,
	// Restore control
	input wire logic start,
	output logic busy,
	// Words handed to the working registers
	output logic ld_valid,
	output logic [$clog2(WORDS)-1:0] ld_addr,
	output logic [W-1:0] ld_data
);
	localparam int AW = $clog2(WORDS);
	localparam logic [AW-1:0] LAST = AW'(WORDS - 1);

	// Array content survives reset, as a real non-volatile cell would
	logic [W-1:0] mem [WORDS];
	logic [WORDS-1:0] written_ff;
	logic [AW-1:0] idx_ff;
	logic busy_ff;
	logic ld_valid_ff;
	logic [AW-1:0] ld_addr_ff;
	logic [W-1:0] ld_data_ff;

	// Programming write
	always_ff @(posedge clk) begin
		if (prog_valid) begin
			mem[prog_addr] <= prog_data;
		end
	end

	// Unwritten words fall back to their defaults
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			written_ff <= '0;
		end else if (prog_valid) begin
			written_ff[prog_addr] <= 1'b1;
		end
	end

	// Copy sequencer: one word per cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_ff <= 1'b0;
			idx_ff <= '0;
		end else if (!busy_ff && start) begin
			busy_ff <= 1'b1;
			idx_ff <= '0;
		end else if (busy_ff) begin
			idx_ff <= idx_ff + 1'b1;
			if (idx_ff == LAST) begin
				busy_ff <= 1'b0;
			end
		end
	end

	// Registered load word
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ld_valid_ff <= 1'b0;
			ld_addr_ff <= '0;
			ld_data_ff <= '0;
		end else begin
			ld_valid_ff <= busy_ff;
			ld_addr_ff <= idx_ff;
			ld_data_ff <= written_ff[idx_ff] ? mem[idx_ff] : DEFAULTS[idx_ff*W +: W];
		end
	end

	// Busy covers the last load word so nothing slips in before it lands
	assign busy = busy_ff | ld_valid_ff;
	assign ld_valid = ld_valid_ff;
	assign ld_addr = ld_addr_ff;
	assign ld_data = ld_data_ff;
endmodule
`default_nettype wire

// ==== verilog/pbsd_status_delay.sv ====
// Status, fault flags, alert, user storage and delay control of the converter controller
`timescale 1ns/10ps
`default_nettype none
module pbsd_status_delay #(
	parameter int TICK_CYCLES = pbsd_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Decoded bus transactions
	input wire logic cmd_valid,
	input wire pbsd_pkg::pbsd_kind_t cmd_kind,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	// Read answer
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	// Converter conditions
	input wire logic output_enable_req,
	input wire logic output_overvoltage_flag_cond,
	input wire logic output_overcurrent_flag_cond,
	input wire logic input_undervoltage_flag_cond,
	input wire logic over_temp_cond,
	input wire logic soft_start_done,
	// Converter control outputs
	output logic switching_on,
	output logic power_good_output,
	// Open-drain alert pin
	output logic alert_o,
	output logic alert_oe,
	// Non-volatile programming port
	input wire logic nvm_prog_valid,
	input wire logic [0:0] nvm_prog_addr,
	input wire logic [7:0] nvm_prog_data
);
	import pbsd_pkg::*;

	typedef enum logic [2:0] {PS_OFF, PS_POD, PS_RAMP, PS_PGD, PS_GOOD, PS_LATCHED} pbsd_pstate_t;

	localparam logic [$clog2(TICK_CYCLES)-1:0] TICK_LAST = ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

	pbsd_pstate_t state_ff;
	pbsd_pstate_t nxt_state;
	logic [7:0] user_ff;
	logic [7:0] delay_ff;
	logic ov_ff, oc_ff, uv_ff, ot_ff, cml_ff;
	logic vsum_ff, isum_ff, insum_ff;
	logic en_prev_ff;
	logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_ff;
	logic [DLY_W-1:0] dly_cnt_ff;
	logic rsp_valid_ff;
	logic [15:0] rsp_data_ff;
	logic tick;
	logic restore_busy;
	logic ld_valid;
	logic [0:0] ld_addr;
	logic [7:0] ld_data;
	logic take;
	logic is_send, is_wr, is_rd_b, is_rd_w;
	logic cmd_bad;
	logic clear_cmd;
	logic restart_clear;
	logic flag_clr;
	logic fault_trip;
	logic delivering;
	logic dly_done;
	logic [15:0] status_word;

	// Pick a delay in ticks from a table entry
	function automatic logic [DLY_W-1:0] pick_delay(input logic [DLY_W-1:0] tbl [8], input logic [2:0] sel);
		pick_delay = tbl[sel];
	endfunction

	// Non-volatile store and restore sequencer
	pbsd_nvm_restore #(
		.WORDS(NVM_WORDS),
		.W(8),
		.DEFAULTS({DELAY_RESET, USER_RESET})
	) u_nvm (
		.clk(ref_clk),
		.nrst(nrst),
		.prog_valid(nvm_prog_valid),
		.prog_addr(nvm_prog_addr),
		.prog_data(nvm_prog_data),
		.start(take && is_send && cmd_code == CMD_RESTORE_ALL),
		.busy(restore_busy),
		.ld_valid(ld_valid),
		.ld_addr(ld_addr),
		.ld_data(ld_data)
	);

	// Commands are dropped during the copy, mimicking an unresponsive device
	assign cmd_ready = !restore_busy;
	assign take = cmd_valid && cmd_ready;
	assign is_send = cmd_kind == KIND_SEND;
	assign is_wr = cmd_kind == KIND_WRITE_BYTE;
	assign is_rd_b = cmd_kind == KIND_READ_BYTE;
	assign is_rd_w = cmd_kind == KIND_READ_WORD;

	// Any code or kind the block does not know counts as a communication fault
	always_comb begin
		if (cmd_code == CMD_CLEAR_FAULTS || cmd_code == CMD_RESTORE_ALL) begin
			cmd_bad = !is_send;
		end else if (cmd_code == CMD_STATUS_BYTE) begin
			cmd_bad = !is_rd_b;
		end else if (cmd_code == CMD_STATUS_WORD) begin
			cmd_bad = !is_rd_w;
		end else if (cmd_code == CMD_USER_STORAGE || cmd_code == CMD_DELAY_SETTINGS) begin
			cmd_bad = !(is_wr || is_rd_b);
		end else begin
			cmd_bad = 1'b1;
		end
	end

	// Clearing events; power cycling is the asynchronous reset itself
	assign clear_cmd = take && is_send && cmd_code == CMD_CLEAR_FAULTS;
	assign restart_clear = output_enable_req && !en_prev_ff;
	assign flag_clr = clear_cmd || restart_clear;

	// Enable history for the off-then-on restart
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			en_prev_ff <= 1'b0;
		end else begin
			en_prev_ff <= output_enable_req;
		end
	end

	// User storage: writes keep only the low six bits, restore overwrites
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			user_ff <= USER_RESET;
		end else if (ld_valid && ld_addr == NVM_IDX_USER) begin
			user_ff <= ld_data & USER_MASK;
		end else if (take && is_wr && cmd_code == CMD_USER_STORAGE) begin
			user_ff <= cmd_wdata & USER_MASK;
		end
	end

	// Delay settings: reset to the 010 codes, restore overwrites
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			delay_ff <= DELAY_RESET;
		end else if (ld_valid && ld_addr == NVM_IDX_DELAY) begin
			delay_ff <= ld_data & DELAY_MASK;
		end else if (take && is_wr && cmd_code == CMD_DELAY_SETTINGS) begin
			delay_ff <= cmd_wdata & DELAY_MASK;
		end
	end

	// Latched fault flags: the live condition wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ov_ff <= 1'b0;
			oc_ff <= 1'b0;
			uv_ff <= 1'b0;
			ot_ff <= 1'b0;
			cml_ff <= 1'b0;
		end else begin
			ov_ff <= output_overvoltage_flag_cond | (ov_ff & !flag_clr);
			oc_ff <= output_overcurrent_flag_cond | (oc_ff & !flag_clr);
			uv_ff <= input_undervoltage_flag_cond | (uv_ff & !flag_clr);
			ot_ff <= over_temp_cond | (ot_ff & !flag_clr);
			cml_ff <= (take & cmd_bad) | (cml_ff & !flag_clr);
		end
	end

	// Group summaries latch with any member event of their group
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			vsum_ff <= 1'b0;
			isum_ff <= 1'b0;
			insum_ff <= 1'b0;
		end else begin
			vsum_ff <= output_overvoltage_flag_cond | (vsum_ff & !flag_clr);
			isum_ff <= output_overcurrent_flag_cond | (isum_ff & !flag_clr);
			insum_ff <= input_undervoltage_flag_cond | (insum_ff & !flag_clr);
		end
	end

	// Microsecond tick from the reference clock
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_ff <= '0;
		end else if (tick) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end
	assign tick = tick_cnt_ff == TICK_LAST;

	// Faults that shut the converter down until an off-then-on restart
	assign fault_trip = output_overvoltage_flag_cond || output_overcurrent_flag_cond || over_temp_cond;

	// Power sequencing state machine
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			PS_OFF: begin
				if (output_enable_req && !input_undervoltage_flag_cond && !fault_trip) begin
					nxt_state = PS_POD;
				end
			end
			PS_LATCHED: begin
				// A clear command does not leave this state
				if (!output_enable_req) begin
					nxt_state = PS_OFF;
				end
			end
			default: begin
				if (!output_enable_req || input_undervoltage_flag_cond) begin
					nxt_state = PS_OFF;
				end else if (fault_trip) begin
					nxt_state = PS_LATCHED;
				end else if (state_ff == PS_POD && dly_done) begin
					nxt_state = PS_RAMP;
				end else if (state_ff == PS_RAMP && soft_start_done) begin
					nxt_state = PS_PGD;
				end else if (state_ff == PS_PGD && dly_done) begin
					nxt_state = PS_GOOD;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= PS_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Delay counter, loaded from the live selects on entry to PS_POD and to PS_PGD
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dly_cnt_ff <= '0;
		end else if (state_ff == PS_OFF && nxt_state == PS_POD) begin
			dly_cnt_ff <= pick_delay(POD_US, delay_ff[POD_LSB +: 3]);
		end else if (state_ff == PS_RAMP && nxt_state == PS_PGD) begin
			dly_cnt_ff <= pick_delay(PGD_US, delay_ff[PGD_LSB +: 3]);
		end else if (tick && dly_cnt_ff != '0) begin
			dly_cnt_ff <= dly_cnt_ff - 1'b1;
		end
	end
	assign dly_done = dly_cnt_ff == '0;

	// Converter outputs
	assign delivering = state_ff == PS_RAMP || state_ff == PS_PGD || state_ff == PS_GOOD;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			switching_on <= 1'b0;
			power_good_output <= 1'b0;
		end else begin
			switching_on <= nxt_state == PS_RAMP || nxt_state == PS_PGD || nxt_state == PS_GOOD;
			power_good_output <= nxt_state == PS_GOOD;
		end
	end

	// Status word assembly; unsupported positions stay zero
	always_comb begin
		status_word = 16'h0000;
		status_word[ST_OFF] = !delivering;
		status_word[ST_OV] = ov_ff;
		status_word[ST_OC] = oc_ff;
		status_word[ST_UV] = uv_ff;
		status_word[ST_OT] = ot_ff;
		status_word[ST_CML] = cml_ff;
		status_word[ST_VSUM] = vsum_ff;
		status_word[ST_ISUM] = isum_ff;
		status_word[ST_INSUM] = insum_ff;
		status_word[ST_PG_LOW] = !power_good_output;
	end

	// Read answers, registered one cycle after the command is taken
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 16'h0000;
		end else begin
			rsp_valid_ff <= take && !cmd_bad && (is_rd_b || is_rd_w);
			if (take && is_rd_w) begin
				rsp_data_ff <= status_word;
			end else if (take && is_rd_b && cmd_code == CMD_STATUS_BYTE) begin
				rsp_data_ff <= {8'h00, status_word[7:0]};
			end else if (take && is_rd_b && cmd_code == CMD_USER_STORAGE) begin
				rsp_data_ff <= {8'h00, user_ff};
			end else if (take && is_rd_b && cmd_code == CMD_DELAY_SETTINGS) begin
				rsp_data_ff <= {8'h00, delay_ff};
			end
		end
	end
	assign rsp_valid = rsp_valid_ff;
	assign rsp_data = rsp_data_ff;

	// Alert pulls low while any latched fault flag is set
	assign alert_o = 1'b0;
	assign alert_oe = ov_ff | oc_ff | uv_ff | ot_ff | cml_ff;
endmodule
`default_nettype wire

// ==== tb/pbsd_status_delay_asserts.sv ====
// Port-level assertions for the status and delay block
`timescale 1ns/10ps
`default_nettype none
module pbsd_status_delay_asserts
	import pbsd_pkg::*;
(
	// Clock, reset and command port
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire pbsd_pkg::pbsd_kind_t cmd_kind,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	// Converter side and alert
	input wire logic output_enable_req,
	input wire logic output_overvoltage_flag_cond,
	input wire logic output_overcurrent_flag_cond,
	input wire logic input_undervoltage_flag_cond,
	input wire logic over_temp_cond,
	input wire logic switching_on,
	input wire logic power_good_output,
	input wire logic alert_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Decoded accepted commands
	wire take = cmd_valid && cmd_ready;
	wire rd_word = take && cmd_kind == KIND_READ_WORD && cmd_code == CMD_STATUS_WORD;
	wire rd_byte = take && cmd_kind == KIND_READ_BYTE && cmd_code == CMD_STATUS_BYTE;
	wire clr = take && cmd_kind == KIND_SEND && cmd_code == CMD_CLEAR_FAULTS;
	wire rest = take && cmd_kind == KIND_SEND && cmd_code == CMD_RESTORE_ALL;
	wire bad = take && !(cmd_code inside {CMD_CLEAR_FAULTS, CMD_RESTORE_ALL, CMD_STATUS_BYTE,
		CMD_STATUS_WORD, CMD_USER_STORAGE, CMD_DELAY_SETTINGS});
	wire any_cond = output_overvoltage_flag_cond || output_overcurrent_flag_cond || input_undervoltage_flag_cond || over_temp_cond;
	// Two-word copy keeps the port shut for three cycles
	sequence copy_s;
		!cmd_ready [*3] ##1 cmd_ready;
	endsequence
	restore_busy_a: assert property (rest |=> copy_s)
		else $error("restore busy window wrong");
	word_answer_a: assert property (rd_word |=> rsp_valid && rsp_data[6] == !$past(switching_on)
		&& rsp_data[11] == !$past(power_good_output)) else $error("status word answer wrong");
	byte_answer_a: assert property (rd_byte |=> rsp_valid && rsp_data[15:8] == 8'h00)
		else $error("status byte answer wrong");
	unused_zero_a: assert property (rsp_valid && $past(rd_word) |-> rsp_data[7] == 1'b0
		&& rsp_data[0] == 1'b0 && rsp_data[12] == 1'b0 && rsp_data[10:8] == 3'h0) else $error("unused bit set");
	ov_alert_a: assert property (output_overvoltage_flag_cond |=> alert_oe)
		else $error("overvoltage not flagged");
	uv_reassert_a: assert property (clr && input_undervoltage_flag_cond |=> alert_oe)
		else $error("present fault not re-flagged");
	clear_release_a: assert property (clr && !any_cond |=> !alert_oe)
		else $error("alert kept after clear");
	flag_hold_a: assert property (alert_oe && !clr && !$rose(output_enable_req) |=> alert_oe)
		else $error("flag dropped without clearing event");
	bad_cmd_a: assert property (bad |=> alert_oe)
		else $error("bad command not flagged");
	pg_on_a: assert property (power_good_output |-> switching_on)
		else $error("power good while not delivering");
endmodule
bind pbsd_status_delay pbsd_status_delay_asserts u_chk (.*);
`default_nettype wire

// ==== tb/pbsd_host_model.sv ====
// Host side: command transfers and alert watching
`timescale 1ns/10ps
`default_nettype none
module pbsd_host_model
	import pbsd_pkg::*;
(
	// Clock and device answers
	input wire logic ref_clk,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic alert_oe,
	// Request
	output logic cmd_valid = 1'b0,
	output var pbsd_pkg::pbsd_kind_t cmd_kind = KIND_SEND,
	output logic [7:0] cmd_code = 8'h00,
	output logic [7:0] cmd_wdata = 8'h00
);
	// Request held until taken; a read answer stands one cycle only
	task automatic xfer(input pbsd_kind_t k, input logic [7:0] c, input logic [7:0] d,
		output logic [15:0] rd, output logic ok);
		int n;
		n = 0;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_code = c;
		cmd_wdata = d;
		// Ready is settled at the falling edge and is what the next rising edge samples
		while (cmd_ready !== 1'b1 && n < 50) begin
			n++;
			@(negedge ref_clk);
		end
		@(posedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_code = ~c; // Released lines must not look valid
		cmd_wdata = ~d;
		rd = rsp_data;
		ok = n < 50 && rsp_valid === (k == KIND_READ_BYTE || k == KIND_READ_WORD);
	endtask
	// Alert starts fault handling instead of status polling
	task automatic wait_alert(output logic seen);
		int n;
		n = 0;
		while (alert_oe !== 1'b1 && n < 20) begin
			n++;
			@(negedge ref_clk);
		end
		seen = alert_oe;
	endtask
endmodule
`default_nettype wire

// ==== tb/pbsd_status_delay_tb_top.sv ====
// Self-checking bench for the status and delay block
`timescale 1ns/10ps
`default_nettype none
module pbsd_status_delay_tb_top;
	import pbsd_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic cmd_valid, cmd_ready, rsp_valid, switching_on, power_good_output, alert_o, alert_oe, ok;
	pbsd_kind_t cmd_kind;
	logic [7:0] cmd_code, cmd_wdata;
	logic [15:0] rsp_data, rd;
	logic en = 1'b0, ov = 1'b0, oc = 1'b0, uv = 1'b0, ot = 1'b0, ssd = 1'b1, pv = 1'b0;
	logic [0:0] pa = 1'h0;
	logic [7:0] pd = 8'h00;
	logic [15:0] msk [4] = '{16'h8020, 16'h4010, 16'h2008, 16'h0004};
	int err_count = 0, comparisons = 0, flg = 0, on_m = 0, pg_m = 0, um = 0, dm = 0, n = 0;
	// Clock
	always #2.5 ref_clk = ~ref_clk;
	pbsd_status_delay #(.TICK_CYCLES(2)) dut (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .output_enable_req(en), .output_overvoltage_flag_cond(ov),
		.output_overcurrent_flag_cond(oc), .input_undervoltage_flag_cond(uv), .over_temp_cond(ot), .soft_start_done(ssd),
		.switching_on(switching_on), .power_good_output(power_good_output), .alert_o(alert_o),
		.alert_oe(alert_oe), .nvm_prog_valid(pv), .nvm_prog_addr(pa), .nvm_prog_data(pd));
	pbsd_host_model host (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .alert_oe(alert_oe), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Expected status from the model flags and converter state
	task automatic chk_status();
		logic [15:0] e;
		e = 16'(flg) | (on_m != 0 ? 16'h0000 : 16'h0040) | (pg_m != 0 ? 16'h0000 : 16'h0800);
		host.xfer(KIND_READ_WORD, CMD_STATUS_WORD, 8'h00, rd, ok);
		cmp("status_word", e, ok ? rd : 16'hDEAD);
		host.xfer(KIND_READ_BYTE, CMD_STATUS_BYTE, 8'h00, rd, ok);
		cmp("status_byte", {8'h00, e[7:0]}, ok ? rd : 16'hDEAD);
	endtask
	task automatic cmd(input pbsd_kind_t k, input logic [7:0] c, input int d);
		host.xfer(k, c, 8'(d), rd, ok);
	endtask
	task automatic rdb(input logic [7:0] c, input int e, input string what);
		host.xfer(KIND_READ_BYTE, c, 8'h00, rd, ok);
		cmp(what, 16'(e), ok ? rd : 16'hDEAD);
	endtask
	task automatic prog(input logic [0:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		pv = 1'b1;
		pa = a;
		pd = d;
		@(negedge ref_clk);
		pv = 1'b0;
		pd = ~d;
	endtask
	// One-cycle pulse on one fault condition
	task automatic fault(input int i);
		@(negedge ref_clk);
		{ov, oc, uv, ot} = 4'h8 >> i;
		@(negedge ref_clk);
		{ov, oc, uv, ot} = 4'h0;
		flg = msk[i];
	endtask
	// Hang guard, far beyond the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(57143));
		repeat (6) @(negedge ref_clk);
		nrst = 1'b1;
		chk_status();
		rdb(CMD_USER_STORAGE, 0, "user");
		rdb(CMD_DELAY_SETTINGS, 'h12, "delay");
		// Random settings; the two top bits never stick
		repeat (4) begin
			um = $urandom % 256;
			dm = $urandom % 256;
			cmd(KIND_WRITE_BYTE, CMD_USER_STORAGE, um);
			cmd(KIND_WRITE_BYTE, CMD_DELAY_SETTINGS, dm);
			rdb(CMD_USER_STORAGE, um & 'h3F, "user");
			rdb(CMD_DELAY_SETTINGS, dm & 'h3F, "delay");
		end
		// Restore, then read at once while the copy holds the port
		um = $urandom % 256;
		prog(1'h0, 8'(um));
		prog(1'h1, 8'hC0);
		cmd(KIND_SEND, CMD_RESTORE_ALL, 0);
		rdb(CMD_USER_STORAGE, um & 'h3F, "user");
		rdb(CMD_DELAY_SETTINGS, 0, "delay");
		for (int i = 0; i < 4; i++) begin
			fault(i);
			host.wait_alert(ok);
			cmp("alert", 16'h1, {15'h0, ok});
			chk_status();
			cmd(KIND_SEND, CMD_CLEAR_FAULTS, 0);
			flg = 0;
			chk_status();
			cmp("alert", 16'h0, {15'h0, alert_oe});
		end
		// Clearing while undervoltage persists
		@(negedge ref_clk);
		uv = 1'b1;
		cmd(KIND_SEND, CMD_CLEAR_FAULTS, 0);
		flg = 'h2008;
		chk_status();
		uv = 1'b0;
		// Unknown code and a write to the read-only word
		cmd(KIND_SEND, 8'h55, 0);
		flg = flg | 'h0002;
		chk_status();
		cmd(KIND_SEND, CMD_CLEAR_FAULTS, 0);
		cmd(KIND_WRITE_BYTE, CMD_STATUS_WORD, 'hFF);
		flg = 'h0002;
		chk_status();
		// Enable rise clears flags; shortest delays give power good
		fault(2);
		@(negedge ref_clk);
		en = 1'b1;
		flg = 0;
		n = 0;
		while (power_good_output !== 1'b1 && n < 3000) begin
			n++;
			@(negedge ref_clk);
		end
		cmp("pg_delay", 16'h1, {15'h0, n >= 2 * (356 + 256) - 8 && n < 2 * (356 + 256) + 46});
		cmp("switching", 16'h1, {15'h0, switching_on});
		cmp("alert_level", 16'h0, {15'h0, alert_o});
		on_m = 1;
		pg_m = 1;
		chk_status();
		// Overvoltage latches off; clearing must not restart
		fault(0);
		cmd(KIND_SEND, CMD_CLEAR_FAULTS, 0);
		flg = 0;
		on_m = 0;
		pg_m = 0;
		// Wait longer than a full power-on delay so a wrongful restart would show
		repeat (800) @(negedge ref_clk);
		chk_status();
		cmp("switching", 16'h0, {15'h0, switching_on});
		en = 1'b0;
		// Supply cycle brings back reset values
		nrst = 1'b0;
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		rdb(CMD_USER_STORAGE, 0, "user");
		rdb(CMD_DELAY_SETTINGS, 'h12, "delay");
		tally_and_finish();
	end
endmodule
`default_nettype wire
